// [rtl/srcp_pkg.sv]
package srcp_pkg;
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_MAX_MHZ = 25;
  localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int NUM_REGS = 16;
  localparam int DIR_POS = 7;
  localparam int CNT_LO_POS = 5;
  localparam int FOUR_LINE_POS = 7;
  localparam int LSB_FIRST_POS = 6;
  localparam int SOFT_RST_POS = 5;
  localparam int BOOST_POS = 6;
  localparam logic [3:0] CFG_REG = 4'h0;
  localparam logic [3:0] BOOST_REG = 4'h6;
  localparam logic [3:0] VERSION_REG = 4'hf;
  // arbitrary neutral version value
  localparam logic [7:0] VERSION_VALUE = 8'h00;
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_TX_OFS = 8'h04;
  localparam logic [7:0] HOST_RX_OFS = 8'h08;
  localparam logic [7:0] HOST_STAT_OFS = 8'h0c;
  localparam logic [9:0] HOST_CTRL_RST = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [7:0] srcp_reg_default(input logic [3:0] a);
    case (a)
      4'h3: srcp_reg_default = 8'h01;
      4'h4: srcp_reg_default = 8'h01;
      4'h5: srcp_reg_default = 8'h80;
      4'h7: srcp_reg_default = 8'h10;
      4'hf: srcp_reg_default = VERSION_VALUE;
      default: srcp_reg_default = 8'h00;
    endcase
  endfunction

  // position within a byte of serial bit number n
  function automatic logic [2:0] srcp_bit_pos(input logic [2:0] n,
                                              input logic lsb);
    srcp_bit_pos = lsb ? n : 3'd7 - n;
  endfunction

  function automatic logic [7:0] srcp_put_bit(input logic [7:0] b,
                                              input logic [2:0] p,
                                              input logic v);
    logic [7:0] r;
    r = b;
    r[p] = v;
    srcp_put_bit = r;
  endfunction
endpackage

// [rtl/srcp_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface srcp_if;
  logic serial_clk;
  logic serial_select_n;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic boost_or_serial_out_pin;
  logic serial_data_io;
  // undriven line floats high as with a pull-up
  assign serial_data_io = dev_data_oe ? dev_data_o :
                          (host_data_oe ? host_data_o : 1'b1);
  modport device(input serial_clk, input serial_select_n,
                 input serial_data_io, output dev_data_o,
                 output dev_data_oe, output boost_or_serial_out_pin);
  modport host(output serial_clk, output serial_select_n,
               output host_data_o, output host_data_oe,
               input serial_data_io, input boost_or_serial_out_pin);
endinterface
`default_nettype wire

// [rtl/srcp_device.sv]
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - clock, active-low select, one shared data line
// - instruction byte then one to four bytes
// - instruction complete at eighth rising edge
// - register written at each byte's eighth bit
// - instruction top bit high means read
// - bits six, five give byte count minus one
// - low five bits give start address
// - host keeps serial clock at most 25 MHz
// - incoming bits sampled on rising clock edge
// - read bits change on falling edge
// - host holds select low whole transaction
// - select high means all activity ignored
// - line input for eight edges, then per direction
// - register zero bit six selects bit order
// - msb first: address decrements per byte
// - lsb first: all bytes lsb first, increment
// - four-line mode sends read data on boost pin
// - hardware reset disables port, restores defaults
// - software reset keeps register zero, clears bit
module srcp_device
  import srcp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  srcp_if.device link,
  output logic [NUM_REGS*8-1:0] o_reg_image,
  output logic o_busy
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INSTR = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ = 5'b01000,
    ST_DONE = 5'b10000
  } srcp_state_e;

  srcp_state_e state_r;
  logic [1:0] sclk_s_r;
  logic [1:0] sel_s_r;
  logic [1:0] sdi_s_r;
  logic sclk_d_r;
  logic [7:0] regs_r [NUM_REGS];
  logic [4:0] addr_r;
  logic [1:0] left_r;
  logic [2:0] bit_r;
  logic [7:0] in_r;
  logic [7:0] out_r;
  logic last_r;
  logic dout_r;
  logic dev_oe_r;
  logic boost_r;
  logic busy_r;

  wire sclk_q = sclk_s_r[1];
  wire sdi = sdi_s_r[1];
  wire sel_on = ~sel_s_r[1];
  // rising edge found from sampled clock
  wire rise = sclk_q & ~sclk_d_r;
  wire fall = ~sclk_q & sclk_d_r;
  // live bit order from register zero
  wire lsb = regs_r[CFG_REG][LSB_FIRST_POS];
  wire four = regs_r[CFG_REG][FOUR_LINE_POS];
  wire [2:0] in_pos = srcp_bit_pos(bit_r, lsb);
  wire [7:0] byte_in = srcp_put_bit(in_r, in_pos, sdi);
  wire byte_end = rise & (bit_r == 3'd7);
  wire [4:0] addr_step = lsb ? 5'(addr_r + 5'd1) : 5'(addr_r - 5'd1);
  wire [4:0] rd_addr = (state_r == ST_INSTR) ? byte_in[4:0] : addr_step;
  wire [7:0] rd_byte = rd_addr[4] ? 8'h00 : regs_r[rd_addr[3:0]];
  // write lands on the byte's eighth bit
  wire wr_hit = (state_r == ST_WRITE) & byte_end & ~addr_r[4] &
                (addr_r[3:0] != VERSION_REG);
  wire soft_rst = wr_hit & (addr_r[3:0] == CFG_REG) &
                  byte_in[SOFT_RST_POS];
  wire [7:0] cfg_kept = srcp_put_bit(byte_in, 3'(SOFT_RST_POS), 1'b0);

  // outside signals pass two flops before use
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      sclk_s_r <= 2'b00;
      sel_s_r <= 2'b11;
      sdi_s_r <= 2'b11;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      sclk_s_r <= {sclk_s_r[0], link.serial_clk};
      sel_s_r <= {sel_s_r[0], link.serial_select_n};
      sdi_s_r <= {sdi_s_r[0], link.serial_data_io};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs_r[i] <= srcp_reg_default(4'(i));
      end
    end
    else if (soft_rst)
    begin
      for (int i = 1; i < NUM_REGS; i++)
      begin
        regs_r[i] <= srcp_reg_default(4'(i));
      end
      regs_r[CFG_REG] <= cfg_kept;
    end
    else if (wr_hit)
    begin
      regs_r[addr_r[3:0]] <= byte_in;
    end
  end

  // port held idle while in reset
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r <= ST_IDLE;
      addr_r <= 5'd0;
      left_r <= 2'd0;
      bit_r <= 3'd0;
      in_r <= 8'h00;
      out_r <= 8'h00;
      last_r <= 1'b0;
      dout_r <= 1'b0;
      dev_oe_r <= 1'b0;
    end
    // select high: nothing is looked at
    else if (!sel_on)
    begin
      state_r <= ST_IDLE;
      bit_r <= 3'd0;
      last_r <= 1'b0;
      dev_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          state_r <= ST_INSTR;
          bit_r <= 3'd0;
        end
        // first eight edges are always input
        ST_INSTR:
        begin
          if (rise)
          begin
            in_r <= byte_in;
            bit_r <= 3'(bit_r + 3'd1);
          end
          if (byte_end)
          begin
            addr_r <= byte_in[4:0];
            left_r <= byte_in[CNT_LO_POS+1:CNT_LO_POS];
            out_r <= rd_byte;
            state_r <= byte_in[DIR_POS] ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (rise)
          begin
            in_r <= byte_in;
            bit_r <= 3'(bit_r + 3'd1);
          end
          if (byte_end)
          begin
            addr_r <= addr_step;
            left_r <= 2'(left_r - 2'd1);
            if (left_r == 2'd0)
            begin
              state_r <= ST_DONE;
            end
          end
        end
        // read bit moves on the falling edge
        ST_READ:
        begin
          if (fall)
          begin
            if (last_r)
            begin
              dev_oe_r <= 1'b0;
              state_r <= ST_DONE;
            end
            else
            begin
              dout_r <= out_r[srcp_bit_pos(bit_r, lsb)];
              // data line stays input in four-line mode
              dev_oe_r <= ~four;
              bit_r <= 3'(bit_r + 3'd1);
              if (bit_r == 3'd7)
              begin
                out_r <= rd_byte;
                addr_r <= addr_step;
                left_r <= 2'(left_r - 2'd1);
                last_r <= (left_r == 2'd0);
              end
            end
          end
        end
        ST_DONE:
        begin
          dev_oe_r <= 1'b0;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // one extra flop keeps the pin glitch free; costs 10 ns
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      boost_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      // boost pin carries read data in four-line
      boost_r <= four ? (dout_r & (state_r == ST_READ)) :
                 regs_r[BOOST_REG][BOOST_POS];
      busy_r <= sel_on & (state_r != ST_DONE);
    end
  end

  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_img
    assign o_reg_image[g*8 +: 8] = regs_r[g];
  end
  assign link.dev_data_o = dout_r;
  assign link.dev_data_oe = dev_oe_r;
  assign link.boost_or_serial_out_pin = boost_r;
  assign o_busy = busy_r;
endmodule
`default_nettype wire

// [rtl/srcp_host.sv]
`timescale 1ns/1ns
`default_nettype none
module srcp_host
  import srcp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  srcp_if.host link,
  input wire logic [7:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [7:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_XFER = 4'b0100,
    H_TAIL = 4'b1000
  } srcp_hstate_e;

  srcp_hstate_e st_r;
  logic awrdy_r, wrdy_r, aw_held_r, w_held_r, bvalid_r, arrdy_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [9:0] ctrl_r;
  logic [31:0] txd_r;
  logic [31:0] rx_r;
  logic [39:0] frame_r;
  logic [7:0] div_r;
  logic [5:0] bit_r;
  logic [5:0] last_bit_r;
  logic sclk_r, seln_r, sdo_r, oe_r, done_r;
  logic [1:0] sd_s_r, bst_s_r;

  wire idle = (st_r == H_IDLE);
  wire do_wr = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_ctrl = do_wr & (awaddr_r == HOST_CTRL_OFS);
  wire wr_tx = do_wr & (awaddr_r == HOST_TX_OFS);
  wire wr_ok = (wr_ctrl & idle) | wr_tx;
  wire start = wr_ctrl & idle;
  wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                           {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] ctrl_new = ({22'd0, ctrl_r} & ~strb_mask) |
                         (wdata_r & strb_mask);
  wire [31:0] tx_new = (txd_r & ~strb_mask) | (wdata_r & strb_mask);
  wire rd_hs = i_axi_arvalid & arrdy_r;
  wire [31:0] rd_val = (i_axi_araddr == HOST_CTRL_OFS) ? {22'd0, ctrl_r} :
                       (i_axi_araddr == HOST_TX_OFS) ? txd_r :
                       (i_axi_araddr == HOST_RX_OFS) ? rx_r :
                       {30'd0, done_r, ~idle};
  wire rd_map = (i_axi_araddr == HOST_CTRL_OFS) |
                (i_axi_araddr == HOST_TX_OFS) |
                (i_axi_araddr == HOST_RX_OFS) |
                (i_axi_araddr == HOST_STAT_OFS);

  wire tick = (div_r == 8'(SCLK_HALF_CYC - 1));
  wire lsb = ctrl_r[8];
  wire is_read = frame_r[DIR_POS];
  wire [5:0] nb = 6'(bit_r + 6'd1);
  wire [2:0] rxb = 3'(bit_r[5:3] - 3'd1);
  wire [4:0] rx_idx = {rxb[1:0], srcp_bit_pos(bit_r[2:0], lsb)};
  wire [5:0] nb_idx = {nb[5:3], srcp_bit_pos(nb[2:0], lsb)};
  // in four-line mode read data comes on boost pin
  wire sd_in = ctrl_r[9] ? bst_s_r[1] : sd_s_r[1];

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      awrdy_r <= 1'b0;
      wrdy_r <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arrdy_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      ctrl_r <= HOST_CTRL_RST;
      txd_r <= 32'h0000_0000;
    end
    else
    begin
      awrdy_r <= ~awrdy_r & ~aw_held_r & ~bvalid_r & i_axi_awvalid;
      wrdy_r <= ~wrdy_r & ~w_held_r & ~bvalid_r & i_axi_wvalid;
      if (i_axi_awvalid & awrdy_r)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_axi_awaddr;
      end
      if (i_axi_wvalid & wrdy_r)
      begin
        w_held_r <= 1'b1;
        wdata_r <= i_axi_wdata;
        wstrb_r <= i_axi_wstrb;
      end
      // busy control writes and unmapped offsets are refused
      if (do_wr)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r & i_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
      if (start)
      begin
        ctrl_r <= ctrl_new[9:0];
      end
      if (wr_tx)
      begin
        txd_r <= tx_new;
      end
      arrdy_r <= ~arrdy_r & ~rvalid_r & i_axi_arvalid;
      if (rd_hs)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_map ? rd_val : 32'h0000_0000;
        rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r & i_axi_rready)
      begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      sd_s_r <= 2'b11;
      bst_s_r <= 2'b00;
    end
    else
    begin
      sd_s_r <= {sd_s_r[0], link.serial_data_io};
      bst_s_r <= {bst_s_r[0], link.boost_or_serial_out_pin};
    end
  end

  // half period fixed well below 25 MHz rate
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_r <= H_IDLE;
      div_r <= 8'd0;
      bit_r <= 6'd0;
      last_bit_r <= 6'd0;
      frame_r <= 40'd0;
      rx_r <= 32'h0000_0000;
      sclk_r <= 1'b0;
      seln_r <= 1'b1;
      sdo_r <= 1'b1;
      oe_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      div_r <= (idle | tick) ? 8'd0 : 8'(div_r + 8'd1);
      case (st_r)
        H_IDLE:
        begin
          if (start)
          begin
            // data bytes come from the held tx word, not the ctrl write
            frame_r <= {txd_r, ctrl_new[7:0]};
            // instruction plus one to four bytes
            last_bit_r <= 6'({ctrl_new[6:5], 3'd0} + 6'd15);
            bit_r <= 6'd0;
            done_r <= 1'b0;
            st_r <= H_LEAD;
          end
        end
        H_LEAD:
        begin
          // select low for the whole transfer
          seln_r <= 1'b0;
          oe_r <= 1'b1;
          // lsb mode shifts instruction lsb first
          sdo_r <= frame_r[{3'd0, srcp_bit_pos(3'd0, lsb)}];
          if (tick)
          begin
            st_r <= H_XFER;
          end
        end
        H_XFER:
        begin
          if (tick)
          begin
            sclk_r <= ~sclk_r;
            // host captures read bit at rising edge
            if (!sclk_r && is_read && bit_r[5:3] != 3'd0)
            begin
              rx_r[rx_idx] <= sd_in;
            end
            if (sclk_r && bit_r == last_bit_r)
            begin
              oe_r <= 1'b0;
              st_r <= H_TAIL;
            end
            else if (sclk_r)
            begin
              bit_r <= nb;
              sdo_r <= frame_r[nb_idx];
              // host lets go of the line for read data
              oe_r <= ~(is_read & (nb[5:3] != 3'd0));
            end
          end
        end
        H_TAIL:
        begin
          if (tick)
          begin
            seln_r <= 1'b1;
            done_r <= 1'b1;
            st_r <= H_IDLE;
          end
        end
        default:
        begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign link.serial_clk = sclk_r;
  assign link.serial_select_n = seln_r;
  assign link.host_data_o = sdo_r;
  assign link.host_data_oe = oe_r;
  assign o_axi_awready = awrdy_r;
  assign o_axi_wready = wrdy_r;
  assign o_axi_bresp = bresp_r;
  assign o_axi_bvalid = bvalid_r;
  assign o_axi_arready = arrdy_r;
  assign o_axi_rdata = rdata_r;
  assign o_axi_rresp = rresp_r;
  assign o_axi_rvalid = rvalid_r;
endmodule
`default_nettype wire

// [sim/srcp_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module srcp_chk
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic serial_clk,
  input wire logic serial_select_n,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe
);
  logic sclk_r;
  logic sclk_rise;
  logic [5:0] rise_cnt_r;
  logic [5:0] rise_cnt_nxt;
  // counter clears while deselected so each frame is judged alone
  assign sclk_rise = serial_clk && !sclk_r;
  assign rise_cnt_nxt = serial_select_n ? 6'h00 :
                        rise_cnt_r + {5'h00, sclk_rise};
  always_ff @(posedge i_clk_sys or posedge i_reset)
    if (i_reset)
    begin
      sclk_r <= 1'b0;
      rise_cnt_r <= 6'h00;
    end
    else
    begin
      sclk_r <= serial_clk;
      rise_cnt_r <= rise_cnt_nxt;
    end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  property p_release_idle;
    serial_select_n [*5] |-> !dev_data_oe;
  endproperty
  a_release_idle: assert property (p_release_idle)
    else $error("device drives the line while deselected");
  property p_one_driver;
    !(dev_data_oe && host_data_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive the data line");
  property p_read_bit_stable;
    $rose(serial_clk) && dev_data_oe |-> $stable(dev_data_o) [*8];
  endproperty
  a_read_bit_stable: assert property (p_read_bit_stable)
    else $error("read bit changed around a rising edge");
  property p_write_bit_stable;
    $rose(serial_clk) && host_data_oe |-> $stable(host_data_o) [*8];
  endproperty
  a_write_bit_stable: assert property (p_write_bit_stable)
    else $error("host bit changed around a rising edge");
  property p_select_lead;
    $fell(serial_select_n) |-> (!serial_select_n && !serial_clk) [*8];
  endproperty
  a_select_lead: assert property (p_select_lead)
    else $error("select or clock moved right after select fell");
  property p_clock_idle;
    serial_select_n |-> !serial_clk;
  endproperty
  a_clock_idle: assert property (p_clock_idle)
    else $error("serial clock high while deselected");
  property p_clock_rate;
    $rose(serial_clk) |=> serial_clk [*8];
  endproperty
  a_clock_rate: assert property (p_clock_rate)
    else $error("serial clock high phase too short");
  property p_turnaround;
    $rose(dev_data_oe) |-> !serial_select_n && !host_data_oe;
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("device drove before host released the line");
  property p_frame_len;
    $rose(serial_select_n) |-> rise_cnt_r[2:0] == 3'h0 &&
      rise_cnt_r >= 6'h10 && rise_cnt_r <= 6'h28;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame is not two to five whole bytes");
  c_read: cover property ($rose(dev_data_oe));
  c_frame: cover property ($fell(serial_select_n));
  c_long: cover property (rise_cnt_r == 6'h28);
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import srcp_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  int oe_cnt = 0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [127:0] image;
  logic [7:0] exp_r [16];
  int checks = 0;
  int n_mismatch = 0;
  srcp_if link_if();
  srcp_device srcp_device_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .link(link_if), .o_reg_image(image), .o_busy(busy));
  srcp_host srcp_host_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .link(link_if), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
    .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(4'hf),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready));
  srcp_chk chk_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .serial_clk(link_if.serial_clk),
    .serial_select_n(link_if.serial_select_n),
    .host_data_o(link_if.host_data_o), .host_data_oe(link_if.host_data_oe),
    .dev_data_o(link_if.dev_data_o), .dev_data_oe(link_if.dev_data_oe));
  always #5 i_clk_sys = ~i_clk_sys;
  wire boost_pin = link_if.boost_or_serial_out_pin;
  // counts cycles in which the device drives the shared line
  always @(posedge i_clk_sys)
    if (link_if.dev_data_oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
  task automatic report_and_stop();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic stall();
    n_mismatch++;
    $display("MISMATCH wait expected answer seen none");
    report_and_stop();
  endtask
  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [127:0] img();
    logic [127:0] v;
    for (int i = 0; i < 16; i++)
      v[8*i +: 8] = exp_r[i];
    return v;
  endfunction
  task automatic defaults();
    foreach (exp_r[i])
      exp_r[i] = 8'h00;
    exp_r[3] = 8'h01;
    exp_r[4] = 8'h01;
    exp_r[5] = 8'h80;
    exp_r[7] = 8'h10;
    exp_r[15] = VERSION_VALUE;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    @(posedge i_clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    while (bvalid !== 1'b1 && n < 100)
    begin
      @(posedge i_clk_sys);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1)
      stall();
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    @(posedge i_clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    while (rvalid !== 1'b1 && n < 100)
    begin
      @(posedge i_clk_sys);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1)
      stall();
  endtask
  task automatic start(input logic [31:0] tx, input logic [9:0] ctrl);
    logic [1:0] r;
    axi_write(HOST_TX_OFS, tx, r);
    axi_write(HOST_CTRL_OFS, {22'h00_0000, ctrl}, r);
  endtask
  // polls status until done; a five-byte frame takes about 1300 clocks
  task automatic wait_done();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    d = 32'h0000_0000;
    n = 0;
    while (d[1] !== 1'b1 && n < 2000)
    begin
      axi_read(HOST_STAT_OFS, d, r);
      n++;
    end
    if (d[1] !== 1'b1)
      stall();
  endtask
  task automatic xfer(input logic [31:0] tx, input logic [9:0] ctrl);
    start(tx, ctrl);
    wait_done();
  endtask
  task automatic read_rx(input string what, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(HOST_RX_OFS, d, r);
    check(what, {96'h0, d}, {96'h0, exp});
  endtask
  task automatic t_reset();
    defaults();
    check("reset image", image, img());
    check("reset boost", {127'h0, boost_pin}, 0);
  endtask
  task automatic t_msb();
    xfer(32'h0000_3ca5, 10'h022);
    exp_r[2] = 8'ha5;
    exp_r[1] = 8'h3c;
    check("msb write", image, img());
    xfer(32'h0000_0000, 10'h0a2);
    read_rx("msb read", 32'h0000_3ca5);
    check("image after read", image, img());
  endtask
  task automatic t_lsb();
    xfer(32'h0000_0040, 10'h000);
    exp_r[0] = 8'h40;
    xfer(32'h4033_2211, 10'h163);
    exp_r[3] = 8'h11;
    exp_r[4] = 8'h22;
    exp_r[5] = 8'h33;
    exp_r[6] = 8'h40;
    check("lsb write", image, img());
    check("boost high", {127'h0, boost_pin}, 1);
    xfer(32'h0000_0000, 10'h1e3);
    read_rx("lsb read", 32'h4033_2211);
  endtask
  task automatic t_soft();
    xfer(32'h0000_0060, 10'h100);
    defaults();
    exp_r[0] = 8'h40;
    check("soft reset", image, img());
  endtask
  task automatic t_refuse();
    logic [31:0] d;
    logic [1:0] r;
    start(32'h0000_0000, 10'h1e3);
    axi_write(HOST_CTRL_OFS, 32'h0000_0100, r);
    check("ctrl busy", {126'h0, r}, {126'h0, RESP_SLVERR});
    check("busy during frame", {127'h0, busy}, 1);
    wait_done();
    read_rx("refuse read", 32'h0080_0101);
    axi_read(8'h10, d, r);
    check("unmapped", {94'h0, r, d}, {94'h0, RESP_SLVERR, 32'h0});
    check("busy after frame", {127'h0, busy}, 0);
    axi_write(HOST_RX_OFS, 32'h0000_0001, r);
    check("rx write", {126'h0, r}, {126'h0, RESP_SLVERR});
    check("image kept", image, img());
  endtask
  // rx keeps stale upper bytes, so a one-byte read only replaces byte 0
  task automatic t_four();
    int c0;
    xfer(32'h0000_00c0, 10'h100);
    exp_r[0] = 8'hc0;
    c0 = oe_cnt;
    xfer(32'h0000_0000, 10'h385);
    read_rx("four-line read", 32'h0080_0180);
    check("line undriven", 128'(oe_cnt - c0), 0);
    check("four-line image", image, img());
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    t_reset();
    t_msb();
    t_lsb();
    t_soft();
    t_refuse();
    t_four();
    report_and_stop();
  end
endmodule
`default_nettype wire
